/* File: hdl/divider_ctl_pkg.sv */
// constants for the dual-modulus divider control: register map, field
// positions, reset values and counter end states
// assumes a 16-bit register port and BCD programming of the main counter
package divider_ctl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int SW_W = 6;
   localparam int DIG_W = 4;
   localparam int MAIN_W = 12;
   localparam int BIN_W = 10;

   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SWALLOW_PROG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MAIN_PROG = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_MAIN_COUNT = 8'h10;

   localparam int CTRL_SIDESTEP_BIT = 0;
   localparam int STATUS_MODSEL_BIT = 8;
   localparam int STATUS_LOAD_BIT = 9;
   localparam int STATUS_SIDE_BIT = 10;
   localparam int STATUS_TC_BIT = 11;

   localparam logic RST_SIDESTEP = 1'h0;
   localparam logic [SW_W-1:0] RST_SWALLOW_PROG = 6'h00;
   localparam logic [MAIN_W-1:0] RST_MAIN_PROG = 12'h117;

   localparam logic [SW_W-1:0] SWALLOW_MAX = 6'h27;
   localparam logic [SW_W-1:0] SWALLOW_END = 6'h3F;
   localparam logic [DIG_W-1:0] DIGIT_MAX = 4'h9;
   localparam logic [BIN_W-1:0] MAIN_MIN = 10'h075;
   localparam logic [BIN_W-1:0] MAIN_MAX = 10'h1A5;
   localparam logic [BIN_W-1:0] MAIN_SPAN = 10'h3E8;
   localparam logic [BIN_W-1:0] SIDESTEP_ADD = 10'h015;
   localparam logic [MAIN_W-1:0] MAIN_DIRECT_END = 12'h999;
   localparam logic [DIG_W-1:0] SIDE_TOP_END = 4'h0;
   localparam logic [7:0] SIDE_LOW_END = 8'h20;
endpackage

/* File: hdl/dual_modulus_divider_control.sv */
// swallow and main counters that steer a 40/41 two-modulus prescaler
// assumes the prescaler output is synchronous to core_clk_i and each of its
// levels lasts at least two core clock cycles
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps

// Notes on behaviour
// R1: swallow counter accepts any programmed value from 0 to 39.
// R2: swallow low stage is radix four, giving the finest channel step; the code has one six-bit binary swallow counter instead.
// R3: swallow top stage has no fixed radix, runs from 0-9 to end; the code has no separate top stage.
// R4: swallow counter is one six-bit binary counter with parallel load.
// R5: main counter is three cascaded decades programmable 117 to 421.
// R6: sidestep: top decade ends one count past all nines, adding 100.
// R7: sidestep: lower two decades end 79 counts early, net plus 21.
// R8: with sidestep on, the alternative end state drives the load signal.
// R9: both counters load on the first falling prescaler edge in load.
// R10: after load modulus select is low unless swallow is 0, enabling swallow; prescaler divides 41.
// R11: swallow end raises modulus select (divide 40) and holds the swallow counter.
// R12: main end holds load low exactly one prescaler period, reloading both.
// R13: prescaler decade inserts one extra state before its top output rises.
// R14: prescaler control stage asks for eleven during one of four periods.
// R15: control stage moves on rising edges; these counters use falling edges.
// R16: all counter stages run from one clock with synchronous parallel load.
// R17: each cycle divides by forty times main plus swallow, plus sidestep.
// R18: reset loads both counters and sets modulus select high.
module dual_modulus_divider_control (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [divider_ctl_pkg::ADDR_W-1:0] addr_i,
   input wire logic [divider_ctl_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [divider_ctl_pkg::DATA_W-1:0] rdata_o,
   input wire logic prescaler_clk_i,
   output logic modsel_o,
   output logic swallow_count_enable_o,
   output logic load_n_o,
   output logic terminal_count_flag_o
);
   import divider_ctl_pkg::*;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   function automatic logic [BIN_W-1:0] bcd_to_bin(input logic [MAIN_W-1:0] b);
      logic [BIN_W-1:0] v;
      v = {6'h00, b[11:8]} * 10'h064;
      v = v + {6'h00, b[7:4]} * 10'h00A;
      v = v + {6'h00, b[3:0]};
      return v;
   endfunction

   function automatic logic [MAIN_W-1:0] bin_to_bcd(input logic [BIN_W-1:0] v);
      logic [MAIN_W-1:0] b;
      b[11:8] = DIG_W'(v / 10'h064);
      b[7:4] = DIG_W'((v / 10'h00A) % 10'h00A);
      b[3:0] = DIG_W'(v % 10'h00A);
      return b;
   endfunction

   // decade cascade: each digit wraps 9 to 0 and carries into the next
   function automatic logic [MAIN_W-1:0] bcd_inc(input logic [MAIN_W-1:0] b);
      logic [MAIN_W-1:0] r;
      logic carry;
      r = b;
      carry = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (carry) begin
            if (b[i*4 +: 4] == DIGIT_MAX) begin
               r[i*4 +: 4] = '0;
            end else begin
               r[i*4 +: 4] = b[i*4 +: 4] + 4'h1;
               carry = 1'b0;
            end
         end
      end
      return r;
   endfunction

   // direct end is all nines; the sidestepped end lies past the wrap to zero
   function automatic logic main_end(input logic [MAIN_W-1:0] b, input logic side);
      logic e;
      if (side) begin
         e = (b[11:8] == SIDE_TOP_END) && (b[7:0] == SIDE_LOW_END); // R6 R7
      end else begin
         e = (b == MAIN_DIRECT_END);
      end
      return e;
   endfunction

   function automatic logic main_prog_ok(input logic [MAIN_W-1:0] b);
      logic [BIN_W-1:0] v;
      v = bcd_to_bin(b);
      return (b[11:8] <= DIGIT_MAX) && (b[7:4] <= DIGIT_MAX) && (b[3:0] <= DIGIT_MAX)
         && (v >= MAIN_MIN) && (v <= MAIN_MAX);
   endfunction

   logic side_en_ff;
   logic [SW_W-1:0] swallow_prog_ff;
   logic [MAIN_W-1:0] main_prog_ff;
   logic clk_prev_ff;
   logic cnt_edge;
   logic [SW_W-1:0] swallow_ff;
   logic [SW_W-1:0] nxt_swallow;
   logic [MAIN_W-1:0] main_ff;
   logic [MAIN_W-1:0] nxt_main;
   logic [MAIN_W-1:0] main_load;
   logic side_act_ff;
   logic nxt_side;
   logic modsel_ff;
   logic load_low_ff;
   logic tc_ff;
   logic reload;
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] status_word;
   logic [BIN_W-1:0] expect_ff;
   logic [BIN_W-1:0] per_cnt_ff;

   // register writes; out-of-range programming values are ignored
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         side_en_ff <= RST_SIDESTEP;
         swallow_prog_ff <= RST_SWALLOW_PROG;
         main_prog_ff <= RST_MAIN_PROG;
      end else if (wr_i) begin
         if (addr_i == OFS_CTRL) begin
            side_en_ff <= wdata_i[CTRL_SIDESTEP_BIT];
         end
         if (addr_i == OFS_SWALLOW_PROG && wdata_i[SW_W-1:0] <= SWALLOW_MAX) begin // R1
            swallow_prog_ff <= wdata_i[SW_W-1:0]; // R2 R3 R4
         end
         if (addr_i == OFS_MAIN_PROG && main_prog_ok(wdata_i[MAIN_W-1:0])) begin // R5
            main_prog_ff <= wdata_i[MAIN_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_ff <= '0;
      end else if (rd_i) begin
         case (addr_i)
            OFS_CTRL: rdata_ff <= DATA_W'(side_en_ff);
            OFS_SWALLOW_PROG: rdata_ff <= DATA_W'(swallow_prog_ff);
            OFS_MAIN_PROG: rdata_ff <= DATA_W'(main_prog_ff);
            OFS_STATUS: rdata_ff <= status_word;
            OFS_MAIN_COUNT: rdata_ff <= DATA_W'(main_ff);
            default: rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   // status word built from the live counter state
   always_comb begin
      status_word = '0;
      status_word[SW_W-1:0] = swallow_ff;
      status_word[STATUS_MODSEL_BIT] = modsel_ff;
      status_word[STATUS_LOAD_BIT] = load_low_ff;
      status_word[STATUS_SIDE_BIT] = side_act_ff;
      status_word[STATUS_TC_BIT] = tc_ff;
   end

   // counters advance on falling edges of the prescaler output
   // the previous level resets low, so a pin idling low gives no false edge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         clk_prev_ff <= 1'b0;
      end else begin
         clk_prev_ff <= prescaler_clk_i;
      end
   end
   assign cnt_edge = clk_prev_ff & ~prescaler_clk_i; // R15
   assign reload = cnt_edge & load_low_ff; // R9
   // up counters, so each cycle starts from the complement of the programmed count
   assign main_load = bin_to_bcd(MAIN_SPAN - bcd_to_bin(main_prog_ff)); // R17

   always_comb begin
      nxt_main = main_ff;
      nxt_side = side_act_ff;
      nxt_swallow = swallow_ff;
      if (reload) begin
         nxt_main = main_load; // R9
         nxt_side = side_en_ff;
         nxt_swallow = ~swallow_prog_ff; // R4
      end else if (cnt_edge) begin
         nxt_main = bcd_inc(main_ff); // R5
         if (!modsel_ff) begin
            nxt_swallow = swallow_ff + 6'h01; // R10
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         main_ff <= bin_to_bcd(MAIN_SPAN - bcd_to_bin(RST_MAIN_PROG)); // R18
         swallow_ff <= ~RST_SWALLOW_PROG; // R18
         side_act_ff <= RST_SIDESTEP;
      end else begin
         main_ff <= nxt_main; // R16
         swallow_ff <= nxt_swallow; // R16
         side_act_ff <= nxt_side;
      end
   end

   // load follows the next count, so it falls on the edge that reaches the end
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         load_low_ff <= 1'b0;
         tc_ff <= 1'b0;
      end else begin
         load_low_ff <= main_end(nxt_main, nxt_side); // R8 R12
         tc_ff <= (nxt_main == MAIN_DIRECT_END);
      end
   end

   // modsel moves only while swallowing and holds high from swallow end to reload
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         modsel_ff <= 1'b1; // R18
      end else if (reload) begin
         modsel_ff <= (nxt_swallow == SWALLOW_END); // R10
      end else if (!modsel_ff) begin
         modsel_ff <= (nxt_swallow == SWALLOW_END); // R11
      end
   end

   assign modsel_o = modsel_ff;
   assign swallow_count_enable_o = ~modsel_ff; // R10 R11
   assign load_n_o = ~load_low_ff;
   assign terminal_count_flag_o = tc_ff;
   assign rdata_o = rdata_ff;

   // prescaler periods per cycle, used only by the checks below
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         expect_ff <= bcd_to_bin(RST_MAIN_PROG) + (RST_SIDESTEP ? SIDESTEP_ADD : '0);
         per_cnt_ff <= '0;
      end else if (reload) begin
         expect_ff <= bcd_to_bin(main_prog_ff) + (side_en_ff ? SIDESTEP_ADD : '0);
         per_cnt_ff <= '0;
      end else if (cnt_edge) begin
         per_cnt_ff <= per_cnt_ff + 10'h001;
      end
   end

   AST_SWALLOW_RANGE: assert property (swallow_prog_ff <= SWALLOW_MAX) // R1
      else $error("swallow programming above 39");

   // one range check per decade stage
   for (genvar g = 0; g < 3; g++) begin : g_digit
      AST_MAIN_DIGITS: assert property (main_ff[g*4 +: 4] <= DIGIT_MAX) // R5
         else $error("main counter digit out of decade range");
   end

   AST_MAIN_LOW_DIGIT: assert property ( // R5
      cnt_edge && !reload |=> main_ff[3:0] ==
         ($past(main_ff[3:0]) == DIGIT_MAX ? 4'h0 : $past(main_ff[3:0]) + 4'h1))
      else $error("lowest decade did not step as a decade counter");

   AST_MAIN_RANGE: assert property (main_prog_ok(main_prog_ff)) // R5
      else $error("main programming outside 117 to 421");

   AST_STEP_ON_FALL: assert property (!cnt_edge |=> $stable(main_ff)) // R15
      else $error("main counter moved without a falling prescaler edge");

   AST_RELOAD_VALUE: assert property ( // R9
      reload |=> main_ff == $past(main_load) && swallow_ff == ~$past(swallow_prog_ff))
      else $error("counters not loaded with programmed values");

   AST_MODSEL_AFTER_LOAD: assert property ( // R10
      reload |=> modsel_o == ($past(swallow_prog_ff) == 6'h00))
      else $error("modulus select wrong after load");

   AST_SWALLOW_END: assert property ( // R11
      cnt_edge && !load_low_ff && !modsel_ff |=> modsel_o == (swallow_ff == SWALLOW_END))
      else $error("modulus select did not follow swallow end");

   AST_SWALLOW_HOLD: assert property ( // R11
      modsel_ff && !reload |=> $stable(swallow_ff) && modsel_ff)
      else $error("swallow counter moved while held");

   // load pulse, end source, cycle length and reset state
   AST_LOAD_ONE_PERIOD: assert property (load_low_ff && !cnt_edge |=> load_low_ff) // R12
      else $error("load released before the next falling prescaler edge");

   AST_LOAD_RELEASE: assert property (reload |=> !load_low_ff) // R12
      else $error("load still low after the reload edge");

   AST_LOAD_ENTRY: assert property (!load_low_ff && !cnt_edge |=> !load_low_ff) // R12
      else $error("load fell without a falling prescaler edge");

   AST_LOAD_NOT_IN_SWALLOW: assert property (load_low_ff |-> modsel_ff) // R11
      else $error("load fell while the swallow counter was still counting");

   AST_RELOAD_CLEARS_TC: assert property (reload |=> !tc_ff) // R12
      else $error("end flag still set after reload");

   AST_END_SOURCE: assert property ( // R8
      load_low_ff |-> (side_act_ff ? main_ff == {SIDE_TOP_END, SIDE_LOW_END}
                                   : main_ff == MAIN_DIRECT_END))
      else $error("load raised from the wrong end state");

   AST_CYCLE_LENGTH: assert property (reload |-> per_cnt_ff == expect_ff - 10'h001) // R17
      else $error("cycle length differs from programmed division");

   AST_RESET_STATE: assert property ($fell(rst_i) |-> modsel_ff && !load_low_ff) // R18
      else $error("reset did not leave modulus select high");

   AST_RESET_SWALLOW: assert property ( // R18
      $fell(rst_i) |-> swallow_ff == SWALLOW_END && !tc_ff)
      else $error("reset did not leave the swallow counter held at its end");

   // swallow stage and modulus select
   AST_ENABLE_UNTIL_END: assert property ( // R11
      swallow_count_enable_o |-> swallow_ff != SWALLOW_END)
      else $error("swallow enable high with the swallow counter at its end");

   AST_SWALLOW_STEP: assert property ( // R10
      cnt_edge && !reload && !modsel_ff |=> swallow_ff == $past(swallow_ff) + 6'h01)
      else $error("swallow counter did not advance while enabled");

   AST_MODSEL_ON_EDGE: assert property (!cnt_edge |=> $stable(modsel_ff)) // R11
      else $error("modulus select moved without a falling prescaler edge");

   // sidestep latch, end flag and cycle count bound
   AST_SIDE_LATCH: assert property (reload |=> side_act_ff == $past(side_en_ff)) // R8
      else $error("sidestep choice not taken at reload");

   AST_SIDE_STABLE: assert property (!reload |=> $stable(side_act_ff)) // R8
      else $error("sidestep choice changed between reloads");

   AST_TC_DIRECT: assert property (tc_ff == (main_ff == MAIN_DIRECT_END)) // R8
      else $error("end flag does not follow the direct end state");

   AST_PER_COUNT_BOUND: assert property (per_cnt_ff < expect_ff) // R17
      else $error("cycle ran past its programmed length");

   COV_SIDESTEP_RELOAD: cover property (reload && side_act_ff);
   COV_ZERO_SWALLOW: cover property (reload && swallow_prog_ff == 6'h00);
   COV_MODSEL_RISE: cover property (!modsel_ff ##1 modsel_ff);
   COV_FULL_SWALLOW: cover property (reload && swallow_prog_ff == SWALLOW_MAX);
   COV_SIDESTEP_END_FLAG: cover property (tc_ff && side_act_ff);
endmodule

/* File: sim/prescaler_model.sv */
// behavioural two-modulus prescaler that answers the divider control
// one core clock stands for one input cycle; free running, no reset
`timescale 1ns/100ps
module prescaler_model (
   input wire logic core_clk_i,
   input wire logic modsel_i,
   output logic prescaler_clk_o
);
   logic [5:0] cnt_ff = 6'h00;
   logic [5:0] low_len_ff = 6'h14;
   logic level_ff = 1'b1;

   assign prescaler_clk_o = level_ff;

   // output falls at period start; modulus chosen late in the low phase
   always @(posedge core_clk_i) begin
      if (cnt_ff == low_len_ff + 6'h13) begin
         cnt_ff <= 6'h00;
         level_ff <= 1'b0;
      end else begin
         cnt_ff <= cnt_ff + 6'h01;
         if (cnt_ff == 6'h12) begin
            low_len_ff <= modsel_i ? 6'h14 : 6'h15;
         end
         if (cnt_ff == low_len_ff - 6'h01) begin
            level_ff <= 1'b1;
         end
      end
   end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the dual-modulus divider control
// assumes the prescaler model on the far side; one 25 MHz clock
`timescale 1ns/100ps
module testbench;
   import divider_ctl_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [ADDR_W-1:0] addr_i = 8'h00;
   logic [DATA_W-1:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [DATA_W-1:0] rdata_o;
   logic prescaler_clk_i;
   logic modsel_o;
   logic swallow_count_enable_o;
   logic load_n_o;
   logic terminal_count_flag_o;
   int err_total = 0;
   int tests_run = 0;
   logic [15:0] lfsr = 16'h002E;

   dual_modulus_divider_control i_dual_modulus_divider_control (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .prescaler_clk_i(prescaler_clk_i),
      .modsel_o(modsel_o), .swallow_count_enable_o(swallow_count_enable_o),
      .load_n_o(load_n_o), .terminal_count_flag_o(terminal_count_flag_o)
   );
   prescaler_model i_prescaler_model (
      .core_clk_i(core_clk_i), .modsel_i(modsel_o), .prescaler_clk_o(prescaler_clk_i)
   );

   always #20 core_clk_i = ~core_clk_i;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [15:0] bcd(input int n);
      return {4'h0, 4'(n / 100), 4'((n / 10) % 10), 4'(n % 10)};
   endfunction

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      @(posedge core_clk_i);
      check("register read", {16'h0000, exp}, {16'h0000, rdata_o});
   endtask

   // cycles from call to the next fall of load, and length of any low phase
   task automatic wait_load(output int cyc, output int low);
      cyc = 0;
      low = 0;
      while (load_n_o !== 1'b1 && cyc < 20000) begin
         @(posedge core_clk_i);
         cyc++;
         low++;
      end
      while (load_n_o !== 1'b0 && cyc < 20000) begin
         @(posedge core_clk_i);
         cyc++;
      end
   endtask

   task automatic scen(input int n, input int a, input logic side);
      int cyc;
      int low;
      reg_wr(OFS_MAIN_PROG, bcd(n));
      reg_wr(OFS_SWALLOW_PROG, 16'(a));
      reg_wr(OFS_CTRL, {15'h0000, side});
      wait_load(cyc, low);
      wait_load(cyc, low);
      check("cycle length", 40 * (side ? n + 21 : n) + a, cyc);
      check("load low length", 40, low);
      check("end flag at load", {31'h0, !side}, {31'h0, terminal_count_flag_o});
      check("modsel at load", 1, {31'h0, modsel_o});
      check("enable inverse", {31'h0, !modsel_o}, {31'h0, swallow_count_enable_o});
   endtask

   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      @(posedge core_clk_i);
      check("modsel after reset", 1, {31'h0, modsel_o});
      check("load after reset", 1, {31'h0, load_n_o});
      rd_chk(OFS_MAIN_PROG, 16'h0117);
      rd_chk(OFS_SWALLOW_PROG, 16'h0000);
      rd_chk(OFS_CTRL, 16'h0000);
      rd_chk(OFS_STATUS, 16'h013F);
      rd_chk(OFS_MAIN_COUNT, bcd(1000 - 117));
      rd_chk(8'h14, 16'h0000);
      reg_wr(OFS_SWALLOW_PROG, 16'h0028);
      rd_chk(OFS_SWALLOW_PROG, 16'h0000);
      reg_wr(OFS_MAIN_PROG, 16'h0116);
      rd_chk(OFS_MAIN_PROG, 16'h0117);
      reg_wr(OFS_MAIN_PROG, 16'h011A);
      rd_chk(OFS_MAIN_PROG, 16'h0117);
      scen(117, 0, 1'b0);
      scen(421, 39, 1'b0);
      scen(117, 39, 1'b1);
      for (int i = 0; i < 2; i++) begin
         lfsr = lfsr_next(lfsr);
         scen(117 + lfsr % 40, lfsr[13:8] % 40, lfsr[4]);
      end
      test_done();
   end

   initial begin
      repeat (90000) @(posedge core_clk_i);
      err_total++;
      test_done();
   end
endmodule
